//--- common/ident_cfg.svh
`ifndef IDENT_CFG_SVH
`define IDENT_CFG_SVH

// ==========================================================
// Register offsets
`define OFS_PORT_CONFIG 16'h0001
`define OFS_CHIP_TYPE 16'h0003
`define OFS_SERIAL_LOW 16'h0004
`define OFS_SERIAL_HIGH 16'h0005
`define OFS_DIE_REVISION 16'h0006
`define OFS_PROTOCOL_VER 16'h000B
`define OFS_VENDOR_LOW 16'h000C
`define OFS_VENDOR_HIGH 16'h000D
`define OFS_COMMIT 16'h000F

// ==========================================================
// Field positions and reset values
`define BIT_READ_BUFFERED 5
`define BIT_COMMIT 0
`define RST_READ_BUFFERED 1'h0
`define RST_RDATA 8'h00

`endif

//--- common/ident_pkg.sv
`default_nettype none

package ident_pkg;

   // ==========================================================
   // Register access from the serial port logic
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } reg_req_t;

   // ==========================================================
   // Whole state of the bank
   typedef struct packed {
      logic [7:0] rdata;
      logic rd_valid;
      logic commit;
      logic read_buffered;
   } ident_state_t;

endpackage : ident_pkg

`default_nettype wire

//--- hw/ident_and_update_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "ident_cfg.svh"

module ident_and_update_regs #(
   parameter logic [3:0] CHIP_TYPE = 4'h9,
   parameter logic [11:0] PART_SERIAL = 12'h2B7,
   parameter logic [7:0] DIE_REVISION = 8'h11,
   parameter logic [7:0] PROTOCOL_VERSION = 8'h21,
   parameter logic [15:0] VENDOR_CODE = 16'h7E3C
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire ident_pkg::reg_req_t req_in,
   output logic [7:0] rdata_out,
   output logic rd_valid_out,
   output logic commit_out,
   output logic read_buffered_out
);
   import ident_pkg::*;

   // The identity parameters above carry arbitrary neutral values.

   ident_state_t state_q;
   ident_state_t state_d;

   // ==========================================================
   // Read decode
   function automatic logic [7:0] read_value(input logic [15:0] addr, input logic rb);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         `OFS_PORT_CONFIG: v[`BIT_READ_BUFFERED] = rb;
         `OFS_CHIP_TYPE: v = {4'h0, CHIP_TYPE};
         `OFS_SERIAL_LOW: v = {PART_SERIAL[3:0], 4'h0};
         `OFS_SERIAL_HIGH: v = PART_SERIAL[11:4];
         `OFS_DIE_REVISION: v = DIE_REVISION;
         `OFS_PROTOCOL_VER: v = PROTOCOL_VERSION;
         `OFS_VENDOR_LOW: v = VENDOR_CODE[7:0];
         `OFS_VENDOR_HIGH: v = VENDOR_CODE[15:8];
         default: v = 8'h00;
      endcase
      return v;
   endfunction : read_value

   // ==========================================================
   // Write decode
   function automatic logic commit_hit(input reg_req_t r);
      // A write with the commit bit low must not fire the strobe.
      return r.wr && (r.addr == `OFS_COMMIT) && r.wdata[`BIT_COMMIT];
   endfunction : commit_hit

   function automatic logic config_hit(input reg_req_t r);
      return r.wr && (r.addr == `OFS_PORT_CONFIG);
   endfunction : config_hit

   // Used by the checks only, to prove that the identification bytes keep no state.
   function automatic logic ident_hit(input logic [15:0] addr);
      logic hit;
      hit = 1'b0;
      case (addr)
         `OFS_CHIP_TYPE, `OFS_SERIAL_LOW, `OFS_SERIAL_HIGH, `OFS_DIE_REVISION: hit = 1'b1;
         `OFS_PROTOCOL_VER, `OFS_VENDOR_LOW, `OFS_VENDOR_HIGH: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : ident_hit

   // ==========================================================
   // Next state
   always_comb begin
      state_d = state_q;
      state_d.rd_valid = req_in.rd;
      // Unmapped reads and the commit register answer zero.
      state_d.rdata = req_in.rd ? read_value(req_in.addr, state_q.read_buffered) : `RST_RDATA;
      // The strobe lives one cycle only; a write of zero is a no-op.
      state_d.commit = commit_hit(req_in);
      // Identification constants have no storage, so writes there fall through.
      if (config_hit(req_in)) begin
         state_d.read_buffered = req_in.wdata[`BIT_READ_BUFFERED];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state_q.rdata <= `RST_RDATA;
         state_q.rd_valid <= 1'b0;
         state_q.commit <= 1'b0;
         state_q.read_buffered <= `RST_READ_BUFFERED;
      end else begin
         state_q <= state_d;
      end
   end

   assign rdata_out = state_q.rdata;
   assign rd_valid_out = state_q.rd_valid;
   assign commit_out = state_q.commit;
   assign read_buffered_out = state_q.read_buffered;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_commit_req;
      req_in.wr && req_in.addr == `OFS_COMMIT && req_in.wdata[`BIT_COMMIT];
   endsequence

   sequence s_no_commit_req;
      !(req_in.wr && req_in.addr == `OFS_COMMIT && req_in.wdata[`BIT_COMMIT]);
   endsequence

   sequence s_commit_zero;
      req_in.wr && req_in.addr == `OFS_COMMIT && !req_in.wdata[`BIT_COMMIT];
   endsequence

   sequence s_read_of(logic [15:0] a);
      req_in.rd && req_in.addr == a;
   endsequence

   sequence s_ident_write;
      req_in.wr && ident_hit(req_in.addr);
   endsequence

   a_chip_type_read:
   assert property (req_in.rd && req_in.addr == `OFS_CHIP_TYPE |=> rd_valid_out && rdata_out == {4'h0, CHIP_TYPE})
      else $error("chip type read wrong");

   a_serial_low_read:
   assert property (req_in.rd && req_in.addr == `OFS_SERIAL_LOW |=> rdata_out == {PART_SERIAL[3:0], 4'h0})
      else $error("serial low read wrong");

   a_serial_high_read:
   assert property (req_in.rd && req_in.addr == `OFS_SERIAL_HIGH |=> rdata_out == PART_SERIAL[11:4])
      else $error("serial high read wrong");

   a_die_rev_read:
   assert property (req_in.rd && req_in.addr == `OFS_DIE_REVISION |=> rdata_out == DIE_REVISION)
      else $error("die revision read wrong");

   a_protocol_read:
   assert property (req_in.rd && req_in.addr == `OFS_PROTOCOL_VER |=> rdata_out == PROTOCOL_VERSION)
      else $error("protocol version read wrong");

   a_vendor_pair_read:
   assert property (req_in.rd && req_in.addr == `OFS_VENDOR_LOW ##1 req_in.rd && req_in.addr == `OFS_VENDOR_HIGH
      |=> {rdata_out, $past(rdata_out)} == VENDOR_CODE)
      else $error("vendor code read wrong");

   a_commit_fires:
   assert property (s_commit_req |=> commit_out)
      else $error("commit strobe missing");

   a_commit_self_clear:
   assert property (s_commit_req ##1 s_no_commit_req |=> !commit_out)
      else $error("commit strobe did not clear");

   a_commit_needs_req:
   assert property (commit_out |-> $past(req_in.wr) && $past(req_in.addr) == `OFS_COMMIT
      && $past(req_in.wdata[`BIT_COMMIT]))
      else $error("commit strobe without request");

   a_read_select_follow:
   assert property (req_in.wr && req_in.addr == `OFS_PORT_CONFIG
      |=> read_buffered_out == $past(req_in.wdata[`BIT_READ_BUFFERED]))
      else $error("read select not updated");

   a_id_write_ignored:
   assert property (req_in.wr && req_in.addr == `OFS_DIE_REVISION ##1 req_in.rd && req_in.addr == `OFS_DIE_REVISION
      |=> rdata_out == DIE_REVISION && !commit_out)
      else $error("identification write took effect");

   // ==========================================================
   // Answer, reset and stability checks
   a_reset_defaults:
   assert property (disable iff (1'b0) !resetn_in |=> read_buffered_out == `RST_READ_BUFFERED && !commit_out
      && !rd_valid_out && rdata_out == `RST_RDATA)
      else $error("reset values wrong");

   a_read_answer_valid:
   assert property (req_in.rd |=> rd_valid_out)
      else $error("read answer missing");

   a_idle_read_quiet:
   assert property (!req_in.rd |=> !rd_valid_out && rdata_out == `RST_RDATA)
      else $error("answer without read");

   a_chip_upper_zero:
   assert property (s_read_of(`OFS_CHIP_TYPE) |=> rdata_out[7:4] == 4'h0)
      else $error("chip type upper nibble not zero");

   a_serial_pair_read:
   assert property (s_read_of(`OFS_SERIAL_LOW) ##1 s_read_of(`OFS_SERIAL_HIGH)
      |=> {rdata_out, $past(rdata_out[7:4])} == PART_SERIAL)
      else $error("serial number pair wrong");

   a_vendor_low_read:
   assert property (s_read_of(`OFS_VENDOR_LOW) |=> rdata_out == VENDOR_CODE[7:0])
      else $error("vendor low byte wrong");

   a_commit_zero_write:
   assert property (s_commit_zero |=> !commit_out)
      else $error("commit on zero write");

   a_commit_reads_zero:
   assert property (s_read_of(`OFS_COMMIT) |=> rdata_out == 8'h00)
      else $error("commit register read not zero");

   a_select_holds:
   assert property (!(req_in.wr && req_in.addr == `OFS_PORT_CONFIG) |=> $stable(read_buffered_out))
      else $error("read select changed without write");

   a_ident_no_commit:
   assert property (s_ident_write |=> !commit_out)
      else $error("identification write committed");

   a_ident_keeps_select:
   assert property (s_ident_write |=> $stable(read_buffered_out))
      else $error("identification write moved read select");

endmodule : ident_and_update_regs

`default_nettype wire

//--- verification/host_model.sv
`timescale 1ns/100ps
`default_nettype none

module host_model
   import ident_pkg::*;
(
   input wire logic clk_in,
   output ident_pkg::reg_req_t req_out
);
   initial req_out = '0;
   // Requests are held to the taking edge, so back-to-back calls need no gap.
   task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
      req_out <= '{a, w, !w, d};
      @(posedge clk_in);
   endtask : xfer
   // Released lines show the inverse so a stale value is never read as valid.
   task automatic idle();
      req_out <= '{~req_out.addr, 1'b0, 1'b0, ~req_out.wdata};
   endtask : idle
endmodule : host_model
`default_nettype wire

//--- verification/ident_and_update_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin failures++; $display("BAD %s %h %h", n, e, s); end end

module ident_and_update_regs_tb;
   import ident_pkg::*;
   // Identity values are arbitrary.
   localparam logic [3:0] CT = 4'h6;
   localparam logic [11:0] PS = 12'hA5C;
   localparam logic [7:0] DR = 8'h3E;
   localparam logic [7:0] PV = 8'h72;
   localparam logic [15:0] VC = 16'hB1D9;
   logic clk_in, resetn_in, exp_commit, exp_rb, rd_valid, commit, rb;
   reg_req_t req;
   logic [7:0] rdata, e, q[$];
   int failures, checks_done;
   host_model host_u (.clk_in(clk_in), .req_out(req));
   ident_and_update_regs #(.CHIP_TYPE(CT), .PART_SERIAL(PS), .DIE_REVISION(DR), .PROTOCOL_VERSION(PV),
      .VENDOR_CODE(VC)) dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .req_in(req), .rdata_out(rdata),
      .rd_valid_out(rd_valid), .commit_out(commit), .read_buffered_out(rb));
   function automatic logic [7:0] expect_of(input logic [15:0] a);
      case (a)
         16'h0003: return {4'h0, CT};
         16'h0004: return {PS[3:0], 4'h0};
         16'h0005: return PS[11:4];
         16'h0006: return DR;
         16'h000B: return PV;
         16'h000C: return VC[7:0];
         16'h000D: return VC[15:8];
         16'h0001: return {2'h0, exp_rb, 5'h00};
         default: return 8'h00;
      endcase
   endfunction : expect_of
   task automatic rd(input logic [15:0] a);
      host_u.xfer(1'b0, a, 8'($urandom));
      q.push_back(expect_of(a));
   endtask : rd
   task automatic finish_test();
      if (failures == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test
   always @(posedge clk_in) begin
      exp_commit <= resetn_in && req.wr && req.addr == 16'h000F && req.wdata[0];
      if (!resetn_in) exp_rb <= 1'b0;
      else if (req.wr && req.addr == 16'h0001) exp_rb <= req.wdata[5];
   end
   always @(posedge clk_in) begin
      #1;
      `CHK("commit_out", exp_commit, commit)
      `CHK("read_buffered_out", exp_rb, rb)
      if (rd_valid !== 1'b0) begin
         `CHK("rd_valid_out", 1'b1, q.size() != 0)
         e = q.pop_front();
         `CHK("rdata_out", e, rdata)
      end else begin
         `CHK("rdata_out_idle", 8'h00, rdata)
      end
   end
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   initial begin
      static logic [15:0] ids[11] = '{16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h000B, 16'h000C, 16'h000D,
         16'h000F, 16'h0001, 16'h0002, 16'h000E};
      resetn_in = 1'b0;
      void'($urandom(83));
      repeat (16) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      foreach (ids[i]) rd(ids[i]);
      foreach (ids[i]) host_u.xfer(1'b1, ids[i], 8'($urandom));
      foreach (ids[i]) rd(ids[i]);
      host_u.xfer(1'b1, 16'h000F, 8'h01);
      host_u.xfer(1'b1, 16'h000F, 8'hFE);
      host_u.xfer(1'b1, 16'h0001, 8'h20);
      rd(16'h0001);
      host_u.xfer(1'b1, 16'h0001, 8'hDF);
      rd(16'h0001);
      host_u.xfer(1'b1, 16'h0006, 8'($urandom));
      rd(16'h0006);
      host_u.idle();
      repeat (3) @(posedge clk_in);
      `CHK("pending reads", 0, q.size())
      finish_test();
   end
   initial begin
      #20000;
      failures++;
      finish_test();
   end
endmodule : ident_and_update_regs_tb
`default_nettype wire
